// *** addr_class_if.sv ***
/*
  Carries one address and its region classification between the guard and
  its region decoder. Assumes the decoder is purely combinational.
*/
`timescale 1ns/1ps
interface addr_class_if;
  import secure_memory_access_guard_pkg::*;
  addr_t addr;
  logic is_secure;
  logic is_pwd;
  logic is_key;
  logic is_ctrl;
  logic is_wcfg;
  logic [2:0] word_idx;
  modport dec (input addr, output is_secure, is_pwd, is_key, is_ctrl, is_wcfg, word_idx);
  modport use_side (output addr, input is_secure, is_pwd, is_key, is_ctrl, is_wcfg, word_idx);
endinterface

// *** mem_partner.sv ***
/*
  Memory array model behind the guard: password words, zero fill below them,
  address-derived data elsewhere. Assumes read data is wanted while the request stands.
*/
`timescale 1ns/1ps
module mem_partner
  import secure_memory_access_guard_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic [1:0] pwd_mode_i,
  input wire logic mem_req_i,
  input wire logic mem_wr_i,
  input wire secure_memory_access_guard_pkg::addr_t mem_addr_i,
  output secure_memory_access_guard_pkg::word_t mem_rdata_o
);
  word_t noise_ff = 16'h0000;
  word_t pwd_word;
  word_t arr_word;
  logic in_pwd;
  logic in_fill;
  // Stored password: all ones in mode 1, all zeros in mode 2, else 0x1111 times word index plus one
  assign pwd_word = (pwd_mode_i == 2'h1) ? 16'hffff : (pwd_mode_i == 2'h2) ? 16'h0000 :
    16'h1111 * {13'h0, mem_addr_i[2:0]} + 16'h1111;
  assign in_pwd = (mem_addr_i >= PWD_LO) && (mem_addr_i <= PWD_HI);
  assign in_fill = (mem_addr_i >= 22'h3f7f80) && (mem_addr_i <= 22'h3f7ff5);
  assign arr_word = in_pwd ? pwd_word : in_fill ? 16'h0000 : mem_addr_i[15:0] ^ 16'h5a5a;
  // Outside a read the bus shows a changing pattern
  assign mem_rdata_o = (mem_req_i && !mem_wr_i) ? arr_word : noise_ff;
  always @(posedge core_clk_i) begin
    noise_ff <= noise_ff + 16'h3c5b;
  end
endmodule

// *** region_decoder.sv ***
/*
  Classifies an address against the secure and special regions.
  Assumes word addresses of the package width; purely combinational.
*/
`timescale 1ns/1ps
module region_decoder (
  addr_class_if.dec cls
);
  import secure_memory_access_guard_pkg::*;
  wire in_lra_a = (cls.addr >= LRA_A_LO) && (cls.addr <= LRA_A_HI);
  wire in_lra_b = (cls.addr >= LRA_B_LO) && (cls.addr <= LRA_B_HI);
  wire in_otp = (cls.addr >= OTP_LO) && (cls.addr <= OTP_HI);
  wire in_flash = (cls.addr >= FLASH_LO) && (cls.addr <= FLASH_HI);
  // Everything outside these four passes unfiltered, save key words, the control word and wait-state writes
  assign cls.is_secure = in_lra_a | in_lra_b | in_otp | in_flash;
  assign cls.is_pwd = (cls.addr >= PWD_LO) && (cls.addr <= PWD_HI);
  assign cls.is_key = (cls.addr >= KEY_LO) && (cls.addr <= KEY_HI);
  assign cls.is_ctrl = (cls.addr == CTRL_ADDR);
  assign cls.is_wcfg = (cls.addr >= WCFG_LO) && (cls.addr <= WCFG_HI);
  assign cls.word_idx = cls.addr[2:0];
endmodule

// *** secure_memory_access_guard.sv ***
/*
  Access filter between the CPU / debug port and the secure memory arrays.
  Assumes one access per cycle on the request port, memory read data in the
  same cycle as mem_req_o, and fetch addresses coming from the same clock.
*/
`timescale 1ns/1ps
module secure_memory_access_guard (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic acc_req_i,
  input wire logic acc_wr_i,
  input wire logic acc_fetch_i,
  input wire logic acc_jtag_i,
  input wire secure_memory_access_guard_pkg::addr_t acc_addr_i,
  input wire secure_memory_access_guard_pkg::word_t acc_wdata_i,
  input wire secure_memory_access_guard_pkg::addr_t pc_i,
  input wire logic protected_write_enable_i,
  input wire secure_memory_access_guard_pkg::word_t mem_rdata_i,
  output logic mem_req_o,
  output logic mem_wr_o,
  output secure_memory_access_guard_pkg::addr_t mem_addr_o,
  output secure_memory_access_guard_pkg::word_t mem_wdata_o,
  output logic rvalid_o,
  output secure_memory_access_guard_pkg::word_t rdata_o,
  output logic secure_o
);
  import secure_memory_access_guard_pkg::*;

  addr_class_if acc_cls ();
  addr_class_if pc_cls ();
  region_decoder u_acc_dec (.cls(acc_cls.dec));
  region_decoder u_pc_dec (.cls(pc_cls.dec));
  assign acc_cls.addr = acc_addr_i;
  assign pc_cls.addr = pc_i;

  word_t key_ff [NUM_WORDS];
  word_t pwd_ff [NUM_WORDS];
  logic [NUM_WORDS-1:0] seen_ff;
  logic secure_ff;
  logic rd_ff;
  logic zero_ff;
  logic loc_ff;
  word_t loc_data_ff;
  logic pwd_hit_ff;
  logic [2:0] pwd_idx_ff;

  // Access classification
  wire do_rd = acc_req_i && !acc_wr_i;
  wire do_wr = acc_req_i && acc_wr_i;
  wire pc_secure = pc_cls.is_secure;
  wire data_ok = !secure_ff || (pc_secure && !acc_jtag_i);
  wire pass_sec = acc_fetch_i || data_ok;
  wire local_hit = acc_cls.is_key || acc_cls.is_ctrl;
  wire wcfg_ok = !secure_ff || pc_secure;
  wire wr_pass = do_wr && !local_hit && (!acc_cls.is_secure || data_ok)
    && (!acc_cls.is_wcfg || (wcfg_ok && protected_write_enable_i));
  wire rd_zero = acc_cls.is_secure && !pass_sec;
  wire key_wr = do_wr && acc_cls.is_key && protected_write_enable_i;
  wire relock = do_wr && acc_cls.is_ctrl && protected_write_enable_i
    && acc_wdata_i[RELOCK_BIT];

  // Password comparison
  wire [NUM_WORDS-1:0] word_match;
  wire [NUM_WORDS-1:0] word_ones;
  wire [NUM_WORDS-1:0] word_zero;
  genvar gi;
  generate
    for (gi = 0; gi < NUM_WORDS; gi++) begin : g_word
      assign word_match[gi] = (key_ff[gi] == pwd_ff[gi]);
      assign word_ones[gi] = (pwd_ff[gi] == ONES_WORD);
      assign word_zero[gi] = (pwd_ff[gi] == ZERO_WORD);
      always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
          key_ff[gi] <= KEY_RST;
          pwd_ff[gi] <= PWD_RST;
          seen_ff[gi] <= 1'b0;
        end else begin
          if (relock) begin
            key_ff[gi] <= KEY_CLR;
          end else if (key_wr && acc_cls.word_idx == 3'(gi)) begin
            key_ff[gi] <= acc_wdata_i;
          end
          if (rd_ff && pwd_hit_ff && pwd_idx_ff == 3'(gi)) begin
            pwd_ff[gi] <= mem_rdata_i;
            seen_ff[gi] <= 1'b1;
          end else if (relock) begin
            seen_ff[gi] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  wire all_seen = &seen_ff;
  wire pwd_ones = &word_ones;
  wire pwd_zero = &word_zero;
  wire unlock = all_seen && !pwd_zero && (pwd_ones || &word_match);
  wire nxt_secure = relock || !unlock;

  wire word_t ctrl_rd = {{(DATA_W-1){1'b0}}, secure_ff};
  wire word_t key_rd = secure_ff ? ZERO_WORD : key_ff[acc_cls.word_idx];
  wire word_t nxt_loc_data = acc_cls.is_ctrl ? ctrl_rd : key_rd;

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      secure_ff <= SECURE_RST;
    end else begin
      secure_ff <= nxt_secure;
    end
  end

  // Request stage
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      mem_req_o <= 1'b0;
      mem_wr_o <= 1'b0;
      mem_addr_o <= '0;
      mem_wdata_o <= ZERO_WORD;
      rd_ff <= 1'b0;
      zero_ff <= 1'b0;
      loc_ff <= 1'b0;
      loc_data_ff <= ZERO_WORD;
      pwd_hit_ff <= 1'b0;
      pwd_idx_ff <= 3'h0;
    end else begin
      mem_req_o <= (do_rd && !local_hit) || wr_pass;
      mem_wr_o <= wr_pass;
      mem_addr_o <= acc_addr_i;
      mem_wdata_o <= acc_wdata_i;
      rd_ff <= do_rd;
      zero_ff <= rd_zero;
      loc_ff <= local_hit;
      loc_data_ff <= nxt_loc_data;
      pwd_hit_ff <= acc_cls.is_pwd;
      pwd_idx_ff <= acc_cls.word_idx;
    end
  end

  // Answer stage
  wire word_t nxt_rdata = loc_ff ? loc_data_ff : (zero_ff ? ZERO_WORD : mem_rdata_i);
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      rvalid_o <= 1'b0;
      rdata_o <= ZERO_WORD;
      secure_o <= SECURE_RST;
    end else begin
      rvalid_o <= rd_ff;
      rdata_o <= rd_ff ? nxt_rdata : ZERO_WORD;
      secure_o <= nxt_secure;
    end
  end

  // Checks
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);

  wire dat_sec = acc_req_i && !acc_fetch_i && acc_cls.is_secure;

  AST_BLOCKED_READ_ZERO: assert property (
    dat_sec && !acc_wr_i && secure_ff && (!pc_secure || acc_jtag_i)
      |-> ##2 (rvalid_o && rdata_o == ZERO_WORD))
    else $error("Blocked secure read did not return zero");
  AST_OUTSIDE_WRITE_DROP: assert property (
    dat_sec && acc_wr_i && secure_ff && !pc_secure |=> !mem_wr_o && !mem_req_o)
    else $error("Secure write from outside passed while secured");
  AST_INSIDE_WRITE_PASS: assert property (
    dat_sec && acc_wr_i && !acc_jtag_i && pc_secure |=> mem_wr_o && mem_addr_o == $past(acc_addr_i))
    else $error("CPU write from secure code was refused");
  AST_DEBUG_WRITE_DROP: assert property (
    dat_sec && acc_wr_i && acc_jtag_i && secure_ff |=> !mem_wr_o)
    else $error("Debug write to secure memory passed while secured");
  AST_FETCH_PASS: assert property (
    acc_req_i && !acc_wr_i && acc_fetch_i && acc_cls.is_secure
      |=> mem_req_o ##1 (rvalid_o && rdata_o == $past(mem_rdata_i)))
    else $error("Instruction fetch into secure memory was blocked");
  AST_UNSECURED_PASS: assert property (
    dat_sec && acc_wr_i && !secure_ff |=> mem_wr_o)
    else $error("Write refused while unsecured");
  AST_ONES_UNLOCK: assert property (
    all_seen && pwd_ones && !relock |=> !secure_o && !secure_ff)
    else $error("All-ones password did not unsecure");
  AST_ZEROS_LOCKED: assert property (
    pwd_zero |=> secure_ff)
    else $error("All-zeros password left device unsecured");
  AST_KEY_NEEDS_PWE: assert property (
    do_wr && acc_cls.is_key && !protected_write_enable_i && !relock
      |=> key_ff[$past(acc_cls.word_idx)] == $past(key_ff[acc_cls.word_idx]))
    else $error("Key word changed without protected writes enabled");
  AST_RELOCK: assert property (
    relock |=> secure_ff && key_ff[0] == KEY_CLR && key_ff[7] == KEY_CLR ##1 secure_o)
    else $error("Force relock did not clear keys and secure");
  AST_WCFG_GUARD: assert property (
    do_wr && acc_cls.is_wcfg && secure_ff && !pc_secure |=> !mem_wr_o)
    else $error("Wait-state write passed while secured from outside");

  COV_UNLOCK: cover property (secure_ff ##1 !secure_ff);
  COV_BLOCKED_READ: cover property (dat_sec && !acc_wr_i && secure_ff && !pc_secure);
  COV_SECURE_CODE_WRITE: cover property (dat_sec && acc_wr_i && pc_secure && secure_ff);
  COV_RELOCK: cover property (!secure_ff ##1 relock);
endmodule

// *** secure_memory_access_guard_pkg.sv ***
/*
  Constants and types for the secure memory access guard: address map of
  filtered and unfiltered regions, key and password word layout, reset values.
  Assumes a 22-bit word address space and 16-bit data words.
*/
// Contract
// - Blocked reads of protected locations return zero, no stall or trap.
// - Protection level follows the current program fetch address.
// - Secured, fetching inside secure memory: CPU data passes, debug port refused.
// - Secured, fetching outside: every data access to secure memory refused.
// - Instruction fetches into secure memory always pass.
// - After a correct unlock, CPU and debug port get full access.
// - Password is eight 16-bit words, each compared with its key word.
// - Password words come from 0x3F7FF8 through 0x3F7FFF.
// - All-ones password: reading the password area alone unsecures.
// - All-zeros password: device stays secured whatever the keys hold.
// - Key words at 0xAE0-0xAE7, written only with protected writes enabled.
// - Small RAMs, peripherals, vector RAM, external zones, high RAM, boot ROM unfiltered.
// - Local RAM blocks at 0x8000-0x9FFF are secure memory.
// - One-time-programmable area and flash/ROM array are secure memory.
// - Wait-state configuration writes only when unsecured or fetching securely.
// - Writing one to force_relock clears keys and secures; it reads zero.
// - Status bit reads one when secured, zero when unsecured.
package secure_memory_access_guard_pkg;
  localparam int ADDR_W = 22;
  localparam int DATA_W = 16;
  localparam int NUM_WORDS = 8;
  typedef logic [ADDR_W-1:0] addr_t;
  typedef logic [DATA_W-1:0] word_t;
  // Secure regions
  localparam addr_t LRA_A_LO = 22'h008000;
  localparam addr_t LRA_A_HI = 22'h008fff;
  localparam addr_t LRA_B_LO = 22'h009000;
  localparam addr_t LRA_B_HI = 22'h009fff;
  localparam addr_t OTP_LO = 22'h3d7800;
  localparam addr_t OTP_HI = 22'h3d7bff;
  localparam addr_t FLASH_LO = 22'h3d8000;
  localparam addr_t FLASH_HI = 22'h3f7fff;
  // Stored password area
  localparam addr_t PWD_LO = 22'h3f7ff8;
  localparam addr_t PWD_HI = 22'h3f7fff;
  // Key words and control word
  localparam addr_t KEY_LO = 22'h000ae0;
  localparam addr_t KEY_HI = 22'h000ae7;
  localparam addr_t CTRL_ADDR = 22'h000aef;
  // Wait-state configuration registers
  localparam addr_t WCFG_LO = 22'h000a80;
  localparam addr_t WCFG_HI = 22'h000a8f;
  // Control word fields
  localparam int RELOCK_BIT = 15;
  localparam int SECURE_BIT = 0;
  // Reset and clear values, word constants
  localparam word_t KEY_RST = 16'hffff;
  localparam word_t KEY_CLR = 16'h0000;
  localparam word_t PWD_RST = 16'h0000;
  localparam word_t ZERO_WORD = 16'h0000;
  localparam word_t ONES_WORD = 16'hffff;
  localparam logic SECURE_RST = 1'b1;
endpackage

// *** secure_memory_access_guard_tb.sv ***
/*
  Self-checking bench for the guard with a memory model behind it.
  Assumes one access at a time, inputs driven at the falling edge.
*/
`timescale 1ns/1ps
module secure_memory_access_guard_tb;
  import secure_memory_access_guard_pkg::*;
  logic clk = 0, rst_n = 0, req = 0, wr = 0, fet = 0, jtg = 0, pwe = 0;
  addr_t addr = '0, pc = '0, maddr;
  word_t wdat = '0, mrd, mwd, rd;
  logic mreq, mwr, rv, sec;
  logic [1:0] mode = 2'h0;
  int fails = 0, samples_checked = 0, cyc = 0;
  localparam addr_t PC_OUT = 22'h000100;
  localparam addr_t PC_IN = 22'h3d8000;
  always #4 clk = ~clk;
  secure_memory_access_guard dut (.core_clk_i(clk), .reset_n_i(rst_n), .acc_req_i(req),
    .acc_wr_i(wr), .acc_fetch_i(fet), .acc_jtag_i(jtg), .acc_addr_i(addr),
    .acc_wdata_i(wdat), .pc_i(pc), .protected_write_enable_i(pwe), .mem_rdata_i(mrd),
    .mem_req_o(mreq), .mem_wr_o(mwr), .mem_addr_o(maddr), .mem_wdata_o(mwd),
    .rvalid_o(rv), .rdata_o(rd), .secure_o(sec));
  mem_partner mem (.core_clk_i(clk), .pwd_mode_i(mode), .mem_req_i(mreq), .mem_wr_i(mwr),
    .mem_addr_i(maddr), .mem_rdata_o(mrd));
  task automatic results();
    $display("checks %0d fails %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      results();
    end
  end
  task automatic chk_w(input word_t g, input word_t e);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk_b(input logic g, input logic e);
    chk_w({15'h0, g}, {15'h0, e});
  endtask
  // One access: forward seen after the taking edge, answer one edge later
  task automatic acc(input logic w, f, j, input addr_t a, input word_t d, input addr_t p,
      output logic fw, output word_t r);
    @(negedge clk);
    {req, wr, fet, jtg, addr, wdat, pc} = {1'b1, w, f, j, a, d, p};
    @(negedge clk);
    req = 1'b0;
    fw = mreq && (mwr === w) && (maddr === a) && (mwd === d);
    @(negedge clk);
    r = rv ? rd : 16'hdead;
  endtask
  task automatic rdc(input addr_t a, input addr_t p, input logic j, f, input word_t e);
    logic fw;
    word_t r;
    acc(1'b0, f, j, a, 16'h0, p, fw, r);
    chk_w(r, e);
  endtask
  task automatic wrc(input addr_t a, input word_t d, input logic e);
    logic fw;
    word_t r;
    pwe = 1'b1;
    acc(1'b1, 1'b0, 1'b0, a, d, pc, fw, r);
    chk_b(fw, e);
  endtask
  task automatic pwd_reads();
    logic fw;
    word_t r;
    for (int i = 0; i < 8; i++) acc(1'b0, 1'b0, 1'b0, PWD_LO + 22'(i), 16'h0, PC_OUT, fw, r);
  endtask
  task automatic keys(input word_t m, input word_t k7, input logic en);
    logic fw;
    word_t r;
    word_t d;
    pwe = en;
    for (int i = 0; i < 8; i++) begin
      d = (i == 7) ? k7 : 16'(m * 16'(i + 1));
      acc(1'b1, 1'b0, 1'b0, KEY_LO + 22'(i), d, PC_OUT, fw, r);
    end
    repeat (3) @(negedge clk);
  endtask
  task automatic do_reset(input logic [1:0] m);
    mode = m;
    rst_n = 1'b0;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    chk_b(sec, SECURE_RST);
  endtask
  task automatic t_secured();
    logic fw;
    word_t r;
    rdc(22'h000100, PC_OUT, 1'b0, 1'b0, 16'h5b5a);
    rdc(22'h3ff000, PC_OUT, 1'b1, 1'b0, 16'haa5a);
    rdc(22'h008010, PC_OUT, 1'b0, 1'b0, 16'h0000);
    rdc(22'h3d8004, PC_OUT, 1'b0, 1'b1, 16'hda5e);
    rdc(22'h3d7800, PC_IN, 1'b0, 1'b0, 16'h225a);
    rdc(22'h009abc, PC_IN, 1'b1, 1'b0, 16'h0000);
    pc = PC_OUT;
    wrc(22'h009000, 16'h1234, 1'b0);
    wrc(WCFG_LO, 16'h0001, 1'b0);
    pc = PC_IN;
    wrc(WCFG_LO, 16'h0001, 1'b1);
    wrc(22'h009000, 16'h1234, 1'b1);
    acc(1'b1, 1'b0, 1'b1, 22'h009004, 16'h0001, PC_IN, fw, r);
    chk_b(fw, 1'b0);
  endtask
  task automatic t_unlock();
    logic fw;
    word_t r;
    pwd_reads();
    keys(16'h1111, 16'h8888, 1'b0);
    chk_b(sec, 1'b1);
    keys(16'h1111, 16'h8888, 1'b1);
    chk_b(sec, 1'b0);
    wrc(22'h3d8010, 16'h5555, 1'b1);
    rdc(22'h008000, PC_OUT, 1'b1, 1'b0, 16'hda5a);
    rdc(KEY_LO + 22'h3, PC_OUT, 1'b0, 1'b0, 16'h4444);
    rdc(CTRL_ADDR, PC_OUT, 1'b0, 1'b0, 16'h0000);
    acc(1'b1, 1'b0, 1'b0, CTRL_ADDR, 16'h8000, PC_OUT, fw, r);
    repeat (2) @(negedge clk);
    chk_b(sec, 1'b1);
    rdc(CTRL_ADDR, PC_OUT, 1'b0, 1'b0, 16'h0001);
    pwd_reads();
    keys(16'h1111, 16'h8887, 1'b1);
    chk_b(sec, 1'b1);
  endtask
  task automatic t_special();
    do_reset(2'h1);
    pwd_reads();
    repeat (3) @(negedge clk);
    chk_b(sec, 1'b0);
    do_reset(2'h2);
    pwd_reads();
    keys(16'h0000, 16'h0000, 1'b1);
    chk_b(sec, 1'b1);
  endtask
  initial begin
    do_reset(2'h0);
    t_secured();
    t_unlock();
    t_special();
    results();
  end
endmodule
